// ===== caller_id_pkg.sv
// constants and types shared by the caller identity serial port
`default_nettype none
package caller_id_pkg;
	localparam int CLOCK_PERIOD_NS = 20;
	localparam int SCLK_PULSE_NS = 500;
	localparam int SCLK_PULSE_CYCLES = (SCLK_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int WORD_READY_NS = 1000;
	localparam int WORD_READY_CYCLES = (WORD_READY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int BITS_PER_WORD = 8;
	localparam int FIFO_DEPTH = 8;
	localparam int COUNT_WIDTH = 8;
	localparam logic MODE_DEVICE_CLOCKED = 1'b0;
	localparam logic MODE_HOST_CLOCKED = 1'b1;
	localparam logic [COUNT_WIDTH-1:0] SCLK_PULSE_LAST = COUNT_WIDTH'(SCLK_PULSE_CYCLES - 1);
	localparam logic [COUNT_WIDTH-1:0] WORD_READY_LAST = COUNT_WIDTH'(WORD_READY_CYCLES - 1);
	localparam logic [2:0] LAST_BIT_INDEX = 3'h7;
	localparam logic [3:0] BITS_PER_WORD_COUNT = 4'h8;
	typedef enum logic [2:0]
	{
		M0_IDLE = 3'b001,
		M0_PULSE = 3'b010,
		M0_READY = 3'b100
	} m0_state_type;
endpackage
`default_nettype wire

// ===== caller_id_serial_port.sv
// byte fifo and serial output side of a caller identity receiver
`default_nettype none

// small synchronous fifo, one struct of state
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_flush,
	// fill side
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	// drain side
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wr;
		logic [AW:0] rd;
	} fifo_type;
	fifo_type s_q, s_d;
	logic [AW:0] used;

	assign used = s_q.wr - s_q.rd;
	assign o_in_ready = (used != (AW+1)'(DEPTH));
	assign o_out_valid = (used != '0);
	assign o_out_data = s_q.mem[s_q.rd[AW-1:0]];

	always_comb
	begin
		s_d = s_q;
		if (i_in_valid && o_in_ready)
		begin
			s_d.mem[s_q.wr[AW-1:0]] = i_in_data;
			s_d.wr = s_q.wr + 1'b1;
		end
		if (i_out_ready && o_out_valid)
			s_d.rd = s_q.rd + 1'b1;
		if (i_flush)
		begin
			s_d.wr = '0;
			s_d.rd = '0;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end
endmodule // byte_fifo

// How it works
// - mode input low selects 0, high 1
// - mode 0 drives shift clock, mode 1 receives
// - mode 0 presents each bit immediately, drops one arriving mid-pulse
// - mode 1 shifts on host clock rising edge
// - power down keeps only trigger path alive
// - demodulated bits accepted only while enabled
// - trigger output flags reversal or ringing
// - trigger output rises after rc interval
// - mode 0 word ready low after byte
// - mode 1 word ready marks byte available
// - carrier present low while in-band signal
// - interrupt low while trigger output low, word ready low or alert tone qualified
module caller_id_serial_port
	import caller_id_pkg::*;
(
	// clock and reset
	input wire logic I_CLOCK,
	input wire logic I_RESET,
	// control pins
	input wire logic I_MODE_SELECT,
	input wire logic I_POWER_DOWN_INPUT,
	input wire logic I_DEMOD_ENABLE,
	// demodulator and tone detector
	input wire logic I_DEMOD_BIT,
	input wire logic I_DEMOD_BIT_VALID,
	input wire logic I_IN_BAND_SIGNAL,
	input wire logic I_ALERT_DETECTED,
	// trigger pins
	input wire logic I_TRIGGER_INPUT,
	input wire logic I_TRIGGER_RC_TIMING,
	output logic O_TRIGGER_RC_TIMING,
	output logic O_TRIGGER_RC_TIMING_OE_N,
	output logic O_TRIGGER_OUTPUT,
	// three-wire port
	input wire logic I_SERIAL_SHIFT_CLOCK,
	output logic O_SERIAL_SHIFT_CLOCK,
	output logic O_SERIAL_SHIFT_CLOCK_OE_N,
	output logic O_DATA,
	output logic O_WORD_READY_N,
	output logic O_BUFFER_READY,
	// status pins
	output logic O_CARRIER_PRESENT_N,
	output logic O_ALERT_TONE_QUALIFIED,
	output logic O_INTERRUPT,
	output logic O_INTERRUPT_OE_N
);
	import caller_id_pkg::*;

	typedef struct packed {
		logic [1:0] mode_s;
		logic [1:0] power_down_input_s;
		logic [1:0] enable_s;
		logic [1:0] trig_s;
		logic [1:0] rc_s;
		logic [1:0] sclk_s;
		logic sclk_prev;
		m0_state_type m0;
		logic [COUNT_WIDTH-1:0] cnt;
		logic [2:0] bit_index;
		logic [7:0] asm_byte;
		logic [2:0] asm_cnt;
		logic asm_valid;
		logic [7:0] shreg;
		logic [3:0] left;
		logic data;
		logic sclk_out;
		logic word_ready_n;
		logic carrier_n;
		logic alert;
		logic trig_out;
		logic rc_drive;
	} state_type;

	state_type s_q, s_d;
	logic active, mode1, accept, edge_seen, pop, fifo_valid;
	logic [7:0] fifo_data;

	assign active = ~s_q.power_down_input_s[1];
	assign mode1 = (s_q.mode_s[1] == MODE_HOST_CLOCKED);
	assign accept = I_DEMOD_BIT_VALID && s_q.enable_s[1] && active;
	assign edge_seen = s_q.sclk_s[1] && !s_q.sclk_prev;
	assign pop = mode1 && active && (s_q.left == 4'h0) && !s_q.asm_valid;

	byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_clk(I_CLOCK),
		.i_rst(I_RESET),
		.i_flush(!active || !mode1),
		.i_in_valid(s_q.asm_valid),
		.i_in_data(s_q.asm_byte),
		.o_in_ready(O_BUFFER_READY),
		.o_out_valid(fifo_valid),
		.o_out_data(fifo_data),
		.i_out_ready(pop && fifo_valid)
	);

	always_comb
	begin
		s_d = s_q;
		s_d.mode_s = {s_q.mode_s[0], I_MODE_SELECT};
		s_d.power_down_input_s = {s_q.power_down_input_s[0], I_POWER_DOWN_INPUT};
		s_d.enable_s = {s_q.enable_s[0], I_DEMOD_ENABLE};
		s_d.trig_s = {s_q.trig_s[0], I_TRIGGER_INPUT};
		s_d.rc_s = {s_q.rc_s[0], I_TRIGGER_RC_TIMING};
		s_d.sclk_s = {s_q.sclk_s[0], I_SERIAL_SHIFT_CLOCK};
		s_d.sclk_prev = s_q.sclk_s[1];
		// discharge rc while trigger high, report once it recharges
		s_d.rc_drive = s_q.trig_s[1];
		s_d.trig_out = s_q.rc_s[1];
		s_d.carrier_n = ~(I_IN_BAND_SIGNAL && active);
		s_d.alert = I_ALERT_DETECTED && active;
		if (s_q.asm_valid && O_BUFFER_READY)
			s_d.asm_valid = 1'b0;
		if (!active)
		begin
			s_d.m0 = M0_IDLE;
			s_d.cnt = '0;
			s_d.bit_index = '0;
			s_d.asm_cnt = '0;
			s_d.asm_valid = 1'b0;
			s_d.left = '0;
			s_d.data = 1'b0;
			s_d.sclk_out = 1'b0;
			s_d.word_ready_n = 1'b1;
		end
		else if (!mode1)
		begin
			s_d.left = '0;
			s_d.asm_cnt = '0;
			case (s_q.m0)
				M0_IDLE, M0_READY:
				begin
					if (s_q.m0 == M0_READY)
					begin
						s_d.cnt = s_q.cnt + 1'b1;
						if (s_q.cnt == WORD_READY_LAST)
						begin
							s_d.word_ready_n = 1'b1;
							s_d.m0 = M0_IDLE;
						end
					end
					if (accept)
					begin
						s_d.data = I_DEMOD_BIT;
						s_d.sclk_out = 1'b1;
						s_d.word_ready_n = 1'b1;
						s_d.cnt = '0;
						s_d.m0 = M0_PULSE;
					end
				end
				M0_PULSE:
				begin
					s_d.cnt = s_q.cnt + 1'b1;
					if (s_q.cnt == SCLK_PULSE_LAST)
					begin
						s_d.sclk_out = 1'b0;
						s_d.cnt = '0;
						s_d.bit_index = s_q.bit_index + 1'b1;
						s_d.m0 = M0_IDLE;
						if (s_q.bit_index == LAST_BIT_INDEX)
						begin
							s_d.word_ready_n = 1'b0;
							s_d.m0 = M0_READY;
						end
					end
				end
				default:
					s_d.m0 = M0_IDLE;
			endcase
		end
		else
		begin
			s_d.m0 = M0_IDLE;
			s_d.sclk_out = 1'b0;
			s_d.bit_index = '0;
			if (accept)
			begin
				s_d.asm_byte = {I_DEMOD_BIT, s_q.asm_byte[7:1]};
				s_d.asm_cnt = s_q.asm_cnt + 1'b1;
				if (s_q.asm_cnt == LAST_BIT_INDEX)
					s_d.asm_valid = 1'b1;
			end
			if (pop && fifo_valid)
			begin
				s_d.shreg = fifo_data;
				s_d.data = fifo_data[0];
				s_d.left = BITS_PER_WORD_COUNT;
				s_d.word_ready_n = 1'b0;
			end
			else if (edge_seen && s_q.left != 4'h0)
			begin
				s_d.shreg = {1'b0, s_q.shreg[7:1]};
				s_d.data = s_q.shreg[1];
				s_d.left = s_q.left - 1'b1;
				s_d.word_ready_n = 1'b1;
			end
		end
	end

	always_ff @(posedge I_CLOCK)
	begin
		if (I_RESET)
		begin
			s_q <= '0;
			s_q.m0 <= M0_IDLE;
			s_q.word_ready_n <= 1'b1;
			s_q.carrier_n <= 1'b1;
			s_q.trig_out <= 1'b1;
			// rc pin idles charged, so no false trigger after reset
			s_q.rc_s <= 2'b11;
		end
		else
			s_q <= s_d;
	end

	assign O_TRIGGER_RC_TIMING = 1'b0;
	assign O_TRIGGER_RC_TIMING_OE_N = ~s_q.rc_drive;
	assign O_TRIGGER_OUTPUT = s_q.trig_out;
	assign O_SERIAL_SHIFT_CLOCK = s_q.sclk_out;
	assign O_SERIAL_SHIFT_CLOCK_OE_N = mode1;
	assign O_DATA = s_q.data;
	assign O_WORD_READY_N = s_q.word_ready_n;
	assign O_CARRIER_PRESENT_N = s_q.carrier_n;
	assign O_ALERT_TONE_QUALIFIED = s_q.alert;
	assign O_INTERRUPT = 1'b0;
	assign O_INTERRUPT_OE_N = ~(!s_q.trig_out || !s_q.word_ready_n || s_q.alert);

	chk_mode_select: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		!mode1 |=> (s_q.left == 4'h0) || mode1)
		else $error("mode 0 loaded a host shift word");
	chk_clock_drive: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		$rose(O_SERIAL_SHIFT_CLOCK) |-> !O_SERIAL_SHIFT_CLOCK_OE_N)
		else $error("shift clock pulsed while not driven");
	chk_bit_prompt: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		(accept && !mode1 && s_q.m0 == M0_IDLE)
		|=> (O_DATA == $past(I_DEMOD_BIT)) && O_SERIAL_SHIFT_CLOCK)
		else $error("mode 0 bit not presented at once");
	chk_host_shift: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		(mode1 && active && edge_seen && !pop && s_q.left > 4'h1)
		|=> O_DATA == $past(s_q.shreg[1]))
		else $error("host edge did not shift next bit");
	chk_power_down: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		!active |=> O_WORD_READY_N && O_CARRIER_PRESENT_N && !O_ALERT_TONE_QUALIFIED)
		else $error("outputs active in power down");
	chk_enable_gate: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		(!s_q.enable_s[1] && s_q.m0 == M0_IDLE) |=> s_q.m0 == M0_IDLE)
		else $error("bit accepted with demod disabled");
	chk_trigger_rc: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		(s_q.trig_s[1] && !s_q.rc_s[0]) |=> !O_TRIGGER_RC_TIMING_OE_N ##1 !O_TRIGGER_OUTPUT)
		else $error("trigger rc path wrong");
	chk_word_mark: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		(active && !mode1 && s_q.m0 == M0_PULSE && s_q.cnt == SCLK_PULSE_LAST
		&& s_q.bit_index == LAST_BIT_INDEX) |=> !O_WORD_READY_N && !O_SERIAL_SHIFT_CLOCK)
		else $error("word ready missing after eighth pulse");
	chk_byte_avail: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		(pop && fifo_valid) |=> !O_WORD_READY_N && (s_q.left == BITS_PER_WORD_COUNT))
		else $error("byte loaded without word ready");
	chk_carrier: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		(I_IN_BAND_SIGNAL && active) |=> !O_CARRIER_PRESENT_N)
		else $error("carrier present not shown");
	chk_interrupt_or: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		(!O_TRIGGER_OUTPUT || !O_WORD_READY_N || O_ALERT_TONE_QUALIFIED) |-> !O_INTERRUPT_OE_N)
		else $error("interrupt not asserted");
	chk_data_hold: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		(mode1 && active && !edge_seen && s_q.left != 4'h0) |=> $stable(O_DATA))
		else $error("mode 1 data moved without edge");
endmodule // caller_id_serial_port
`default_nettype wire

// ===== host_reader.sv
// microcontroller model that clocks bytes out of the three-wire port
`default_nettype none
module host_reader (
	// control from the bench
	input wire logic i_go,
	input wire logic i_slow,
	// three-wire port
	input wire logic i_word_ready_n,
	input wire logic i_data,
	output logic o_sclk
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] got [0:15];
	logic [7:0] shift;
	logic glitch;
	int count;
	initial
	begin
		// clock stands low outside frames
		o_sclk = 1'b0;
		glitch = 1'b0;
		count = 0;
		forever
		begin
			wait (i_go === 1'b1 && i_word_ready_n === 1'b0);
			// keep host edges off the device clock edges
			#(i_slow ? 2005 : 45);
			for (int k = 0; k < 8; k++)
			begin
				shift[k] = i_data;
				o_sclk = 1'b1;
				#40;
				if (i_data !== shift[k]) glitch = 1'b1;
				#40;
				o_sclk = 1'b0;
				#80;
			end
			got[count] = shift;
			count++;
			#100;
		end
	end
endmodule // host_reader
`default_nettype wire

// ===== caller_id_serial_port_tb.sv
// self-checking bench for the caller identity serial port
`default_nettype none
module caller_id_serial_port_tb;
	import caller_id_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int RC_CYCLES = 40;
	logic I_CLOCK, I_RESET, I_MODE_SELECT, I_POWER_DOWN_INPUT, I_DEMOD_ENABLE, I_DEMOD_BIT;
	logic I_DEMOD_BIT_VALID, I_IN_BAND_SIGNAL, I_ALERT_DETECTED, I_TRIGGER_INPUT;
	logic O_TRIGGER_RC_TIMING, O_TRIGGER_RC_TIMING_OE_N, O_TRIGGER_OUTPUT, O_DATA;
	logic O_SERIAL_SHIFT_CLOCK, O_SERIAL_SHIFT_CLOCK_OE_N, O_WORD_READY_N, O_BUFFER_READY;
	logic O_CARRIER_PRESENT_N, O_ALERT_TONE_QUALIFIED, O_INTERRUPT, O_INTERRUPT_OE_N;
	logic I_SERIAL_SHIFT_CLOCK, I_TRIGGER_RC_TIMING, host_sclk, host_go, host_slow;
	int miscompares = 0, n_compared = 0, cycles = 0, rc_count = RC_CYCLES, seed;
	logic [7:0] exp_bytes [0:15];
	// shared pins: whoever has the enable drives
	assign I_SERIAL_SHIFT_CLOCK = O_SERIAL_SHIFT_CLOCK_OE_N ? host_sclk : O_SERIAL_SHIFT_CLOCK;
	assign I_TRIGGER_RC_TIMING = !O_TRIGGER_RC_TIMING_OE_N ? O_TRIGGER_RC_TIMING
		: (rc_count >= RC_CYCLES);
	caller_id_serial_port u_dut (.*);
	host_reader u_host (.i_go(host_go), .i_slow(host_slow), .i_word_ready_n(O_WORD_READY_N),
		.i_data(O_DATA), .o_sclk(host_sclk));
	initial
	begin
		I_CLOCK = 1'b0;
		forever #10 I_CLOCK = ~I_CLOCK;
	end
	// external rc recharges once released
	always @(posedge I_CLOCK) rc_count <= O_TRIGGER_RC_TIMING_OE_N ? rc_count + 1 : 0;
	task automatic cyc(input int n);
		repeat (n) @(posedge I_CLOCK);
		#2;
	endtask
	task automatic chk1(input string what, input logic e, input logic g);
		n_compared++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %s expected %b seen %b", what, e, g);
		end
	endtask
	task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic send_byte(input logic [7:0] v, input bit look);
		for (int i = 0; i < 8; i++)
		begin
			I_DEMOD_BIT = v[i];
			I_DEMOD_BIT_VALID = 1'b1;
			cyc(1);
			I_DEMOD_BIT_VALID = 1'b0;
			cyc(1);
			if (look) chk1("data", v[i], O_DATA);
			if (look) chk1("shift clock", 1'b1, O_SERIAL_SHIFT_CLOCK);
			cyc(28);
		end
	endtask
	task automatic stop_test;
		$display("counts: %0d compared, %0d bad", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge I_CLOCK)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			miscompares++;
			stop_test();
		end
	end
	initial
	begin
		seed = 32'ha3aaeea9;
		{I_MODE_SELECT, I_POWER_DOWN_INPUT, I_DEMOD_ENABLE, I_DEMOD_BIT} = 4'h0;
		{I_DEMOD_BIT_VALID, I_IN_BAND_SIGNAL, I_ALERT_DETECTED, I_TRIGGER_INPUT} = 4'h0;
		{host_go, host_slow} = 2'h0;
		I_RESET = 1'b1;
		cyc(10);
		I_RESET = 1'b0;
		chk1("trigger output", 1'b1, O_TRIGGER_OUTPUT);
		chk1("word ready", 1'b1, O_WORD_READY_N);
		chk1("interrupt", 1'b1, O_INTERRUPT_OE_N);
		chk1("interrupt level", 1'b0, O_INTERRUPT);
		chk1("clock drive", 1'b0, O_SERIAL_SHIFT_CLOCK_OE_N);
		I_DEMOD_BIT_VALID = 1'b1;
		cyc(1);
		I_DEMOD_BIT_VALID = 1'b0;
		cyc(2);
		chk1("idle clock", 1'b0, O_SERIAL_SHIFT_CLOCK);
		I_DEMOD_ENABLE = 1'b1;
		cyc(4);
		for (int n = 0; n < 2; n++)
		begin
			send_byte(n ? 8'($random(seed)) : 8'h80, 1'b1);
			cyc(2);
			chk1("word ready", 1'b0, O_WORD_READY_N);
			chk1("interrupt", 1'b0, O_INTERRUPT_OE_N);
			cyc(50);
			chk1("word ready", 1'b1, O_WORD_READY_N);
		end
		$display("test device clocked done");
		I_MODE_SELECT = 1'b1;
		cyc(6);
		chk1("clock drive", 1'b1, O_SERIAL_SHIFT_CLOCK_OE_N);
		host_go = 1'b1;
		for (int n = 0; n < 11; n++)
		begin
			if (n == 2) host_go = 1'b0;
			exp_bytes[n] = n == 2 ? 8'hff : 8'($random(seed));
			send_byte(exp_bytes[n], 1'b0);
		end
		chk1("buffer ready", 1'b0, O_BUFFER_READY);
		chk1("word ready", 1'b0, O_WORD_READY_N);
		{host_go, host_slow} = 2'h3;
		repeat (3000) if (u_host.count < 11) cyc(1);
		for (int n = 0; n < 11; n++) chk8("byte", exp_bytes[n], u_host.got[n]);
		chk1("data held", 1'b0, u_host.glitch);
		$display("test host clocked done");
		{I_IN_BAND_SIGNAL, I_ALERT_DETECTED} = 2'h3;
		cyc(2);
		chk1("carrier", 1'b0, O_CARRIER_PRESENT_N);
		chk1("alert", 1'b1, O_ALERT_TONE_QUALIFIED);
		chk1("interrupt", 1'b0, O_INTERRUPT_OE_N);
		{I_IN_BAND_SIGNAL, I_ALERT_DETECTED} = 2'h0;
		cyc(2);
		chk1("carrier", 1'b1, O_CARRIER_PRESENT_N);
		chk1("interrupt", 1'b1, O_INTERRUPT_OE_N);
		$display("test status done");
		{I_MODE_SELECT, I_POWER_DOWN_INPUT, I_DEMOD_BIT, I_DEMOD_BIT_VALID} = 4'h7;
		cyc(1);
		I_DEMOD_BIT_VALID = 1'b0;
		cyc(6);
		I_DEMOD_BIT_VALID = 1'b1;
		cyc(1);
		I_DEMOD_BIT_VALID = 1'b0;
		cyc(1);
		chk1("idle clock", 1'b0, O_SERIAL_SHIFT_CLOCK);
		I_TRIGGER_INPUT = 1'b1;
		cyc(8);
		chk1("trigger output", 1'b0, O_TRIGGER_OUTPUT);
		chk1("interrupt", 1'b0, O_INTERRUPT_OE_N);
		I_TRIGGER_INPUT = 1'b0;
		cyc(20);
		chk1("trigger output", 1'b0, O_TRIGGER_OUTPUT);
		cyc(40);
		chk1("trigger output", 1'b1, O_TRIGGER_OUTPUT);
		$display("test trigger done");
		stop_test();
	end
endmodule // caller_id_serial_port_tb
`default_nettype wire
